// [logic/adc_config_trigger_result_format.sv]
// Converter control: clock select, reference select, auto trigger and result justification
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctl_defines.svh"

module adc_config_trigger_result_format
   import adc_ctl_pkg::*;
#(
   parameter int RESULT_W = 10,
   parameter int SYNC_STAGES = 2
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register port
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   // Interrupt
   output logic irq,
   // Conversion core
   input wire logic rcOscTick,
   input wire logic convDone,
   input wire logic [9:0] convData,
   output logic convGo,
   output logic convClkTick,
   output logic convClkIsRc,
   // Reference selects
   output logic negRefPin,
   output logic posRefSupply,
   output logic posRefPin,
   output logic posRefFvr,
   // Trigger sources
   input wire logic capture_unit_1,
   input wire logic capture_unit_2,
   input wire logic timer0_wrap_pulse,
   input wire logic timer1_wrap_pulse,
   input wire logic timer2_match_pulse,
   input wire logic comparator1_synced_out,
   input wire logic comparator2_synced_out,
   input wire logic logic_cell1_out,
   input wire logic logic_cell2_out,
   input wire logic logic_cell3_out,
   input wire logic logic_cell4_out,
   input wire logic timer4_match_pulse,
   input wire logic timer6_match_pulse,
   // Pulse of the selected trigger
   output logic trigPulse
);

   // The logic is built for a 10-bit result and a two-stage synchroniser
   if (RESULT_W != 10) begin : g_bad_width
      $error("RESULT_W must be 10");
   end
   if (SYNC_STAGES != 2) begin : g_bad_sync
      $error("SYNC_STAGES must be 2");
   end

   // Divide ratio for a clock code; RC codes return zero
   function automatic logic [6:0] divRatio(input logic [2:0] code);
      logic [6:0] r;
      r = 7'h00;
      unique case (conv_clk_t'(code))
         CLK_DIV2: r = `DIV_2;
         CLK_DIV8: r = `DIV_8;
         CLK_DIV32: r = `DIV_32;
         CLK_DIV4: r = `DIV_4;
         CLK_DIV16: r = `DIV_16;
         CLK_DIV64: r = `DIV_64;
         CLK_RC_A: r = 7'h00;
         CLK_RC_B: r = 7'h00;
      endcase
      return r;
   endfunction : divRatio

   // Register read view of the format and clock register
   function automatic logic [7:0] fmtView(input state_t s);
      logic [7:0] v;
      v = 8'h00;
      v[`POS_JUSTIFY] = s.justify;
      v[`POS_CLKSEL_HI:`POS_CLKSEL_LO] = s.clkSel;
      v[`POS_NEGREF] = s.negRef;
      v[`POS_POSREF_HI:`POS_POSREF_LO] = s.posRef;
      return v;
   endfunction : fmtView

   state_t st_r;
   state_t st_nxt;
   logic [12:0] trigRaw;
   logic [12:0] trigRise;
   logic trigHit;
   logic swGoSet;
   logic swGoClr;
   logic [6:0] ratio;
   logic [7:0] loadHigh;
   logic [7:0] loadLow;
   logic [1:0] irqEvt;

   // Sources gathered in code order, code 0001 in bit 0
   assign trigRaw = {
      timer6_match_pulse,
      timer4_match_pulse,
      logic_cell4_out,
      logic_cell3_out,
      logic_cell2_out,
      logic_cell1_out,
      comparator2_synced_out,
      comparator1_synced_out,
      timer2_match_pulse,
      timer1_wrap_pulse,
      timer0_wrap_pulse,
      capture_unit_2,
      capture_unit_1
   };

   // Only the stage behind the synchroniser is edge detected
   assign trigRise = st_r.sync2 & ~st_r.sync3;

   // Trigger mux; zero and reserved codes select nothing
   always_comb begin
      trigHit = 1'b0;
      if (st_r.trigSel >= 4'h1 && st_r.trigSel <= 4'hd) begin
         trigHit = trigRise[st_r.trigSel - 4'h1];
      end
   end

   // Justified images of the incoming result
   always_comb begin
      if (st_r.justify) begin
         loadHigh = {6'h00, convData[9:8]};
         loadLow = convData[7:0];
      end else begin
         loadHigh = convData[9:2];
         loadLow = {convData[1:0], 6'h00};
      end
   end

   // Software start and stop through the conversion control register
   assign swGoSet = regWrite && regAddr == `OFS_CONV_CTRL && regWdata[`POS_GO];
   assign swGoClr = regWrite && regAddr == `OFS_CONV_CTRL && !regWdata[`POS_GO];
   assign ratio = divRatio(st_r.clkSel);
   assign irqEvt[`POS_IRQ_DONE] = convDone && st_r.go;
   assign irqEvt[`POS_IRQ_TRIG] = trigHit;

   // Next state
   always_comb begin
      st_nxt = st_r;
      // Three flops per source; the first is read only by the second
      st_nxt.sync1 = trigRaw;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.sync3 = st_r.sync2;
      // Divided clock tick, or the RC tick passed through
      if (ratio == 7'h00) begin
         st_nxt.divCnt = 7'h00;
         st_nxt.clkTick = rcOscTick;
      end else if (st_r.divCnt >= ratio - 7'h01) begin
         st_nxt.divCnt = 7'h00;
         st_nxt.clkTick = 1'b1;
      end else begin
         st_nxt.divCnt = st_r.divCnt + 7'h01;
         st_nxt.clkTick = 1'b0;
      end
      // Register writes
      if (regWrite) begin
         unique case (regAddr)
            `OFS_CTRL_FMT: begin
               st_nxt.justify = regWdata[`POS_JUSTIFY];
               st_nxt.clkSel = regWdata[`POS_CLKSEL_HI:`POS_CLKSEL_LO];
               st_nxt.negRef = regWdata[`POS_NEGREF];
               st_nxt.posRef = regWdata[`POS_POSREF_HI:`POS_POSREF_LO];
            end
            `OFS_CTRL_TRIG: begin
               st_nxt.trigSel = regWdata[`POS_TRIG_HI:`POS_TRIG_LO];
            end
            `OFS_RES_HIGH: begin
               st_nxt.resHigh = regWdata;
            end
            `OFS_RES_LOW: begin
               st_nxt.resLow = regWdata;
            end
            `OFS_IRQ_STATUS: begin
               st_nxt.irqStat = st_r.irqStat & ~regWdata[1:0];
            end
            `OFS_IRQ_MASK: begin
               st_nxt.irqMask = regWdata[1:0];
            end
            default: begin
            end
         endcase
      end
      // Events set after the clear so a same-cycle event survives
      st_nxt.irqStat = st_nxt.irqStat | irqEvt;
      // Completion loads the result; it overrides a same-cycle software write
      if (convDone && st_r.go) begin
         st_nxt.resHigh = loadHigh;
         st_nxt.resLow = loadLow;
      end
      // In-progress bit: trigger and software start win over clear and done
      if (trigHit || swGoSet) begin
         st_nxt.go = 1'b1;
      end else if (convDone || swGoClr) begin
         st_nxt.go = 1'b0;
      end
      // Read data stands in the cycle after the strobe only
      st_nxt.rdata = 8'h00;
      if (regRead) begin
         unique case (regAddr)
            `OFS_CTRL_FMT: st_nxt.rdata = fmtView(st_r);
            `OFS_CTRL_TRIG: st_nxt.rdata = {st_r.trigSel, 4'h0};
            `OFS_RES_HIGH: st_nxt.rdata = st_r.resHigh;
            `OFS_RES_LOW: st_nxt.rdata = st_r.resLow;
            `OFS_IRQ_STATUS: st_nxt.rdata = {6'h00, st_r.irqStat};
            `OFS_IRQ_MASK: st_nxt.rdata = {6'h00, st_r.irqMask};
            `OFS_CONV_CTRL: st_nxt.rdata = {7'h00, st_r.go};
            default: st_nxt.rdata = 8'h00;
         endcase
      end
   end

   // State register; results are left out of the reset branch so they keep their value
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r.justify <= 1'(`RST_CTRL_FMT >> `POS_JUSTIFY);
         st_r.clkSel <= 3'h0;
         st_r.negRef <= 1'b0;
         st_r.posRef <= 2'h0;
         st_r.trigSel <= 4'(`RST_CTRL_TRIG >> `POS_TRIG_LO);
         st_r.go <= 1'b0;
         st_r.irqStat <= `RST_IRQ;
         st_r.irqMask <= `RST_IRQ;
         st_r.divCnt <= 7'h00;
         st_r.clkTick <= 1'b0;
         st_r.sync1 <= 13'h0000;
         st_r.sync2 <= 13'h0000;
         st_r.sync3 <= 13'h0000;
         st_r.rdata <= 8'h00;
      end else begin
         st_r.justify <= st_nxt.justify;
         st_r.clkSel <= st_nxt.clkSel;
         st_r.negRef <= st_nxt.negRef;
         st_r.posRef <= st_nxt.posRef;
         st_r.trigSel <= st_nxt.trigSel;
         st_r.go <= st_nxt.go;
         st_r.irqStat <= st_nxt.irqStat;
         st_r.irqMask <= st_nxt.irqMask;
         st_r.divCnt <= st_nxt.divCnt;
         st_r.clkTick <= st_nxt.clkTick;
         st_r.sync1 <= st_nxt.sync1;
         st_r.sync2 <= st_nxt.sync2;
         st_r.sync3 <= st_nxt.sync3;
         st_r.rdata <= st_nxt.rdata;
         // Results: undefined at power-up, held while reset is active
         st_r.resHigh <= st_nxt.resHigh;
         st_r.resLow <= st_nxt.resLow;
      end
   end

   // Outputs
   assign regRdata = st_r.rdata;
   assign irq = |(st_r.irqStat & st_r.irqMask);
   assign convGo = st_r.go;
   assign convClkTick = st_r.clkTick;
   assign convClkIsRc = st_r.clkSel[1] & st_r.clkSel[0];
   assign negRefPin = st_r.negRef;
   assign posRefSupply = st_r.posRef == 2'h0;
   assign posRefPin = st_r.posRef == 2'h2;
   assign posRefFvr = st_r.posRef == 2'h3;
   // Sources are only tapped here, their own flags stay with their peripherals
   assign trigPulse = trigHit;

endmodule : adc_config_trigger_result_format
`default_nettype wire

// [pkg/adc_ctl_defines.svh]
// Offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADC_CTL_DEFINES_SVH
`define ADC_CTL_DEFINES_SVH
// Register offsets
`define OFS_CTRL_FMT 3'h0
`define OFS_CTRL_TRIG 3'h1
`define OFS_RES_HIGH 3'h2
`define OFS_RES_LOW 3'h3
`define OFS_IRQ_STATUS 3'h4
`define OFS_IRQ_MASK 3'h5
`define OFS_CONV_CTRL 3'h6
// Field positions in the format and clock register
`define POS_JUSTIFY 7
`define POS_CLKSEL_HI 6
`define POS_CLKSEL_LO 4
`define POS_NEGREF 2
`define POS_POSREF_HI 1
`define POS_POSREF_LO 0
// Field positions in the trigger register
`define POS_TRIG_HI 7
`define POS_TRIG_LO 4
// Status, mask and conversion control bit positions
`define POS_IRQ_DONE 0
`define POS_IRQ_TRIG 1
`define POS_GO 0
// Reset values
`define RST_CTRL_FMT 8'h00
`define RST_CTRL_TRIG 8'h00
`define RST_IRQ 2'h0
// Clock divide ratios
`define DIV_2 7'h02
`define DIV_4 7'h04
`define DIV_8 7'h08
`define DIV_16 7'h10
`define DIV_32 7'h20
`define DIV_64 7'h40
`endif

// [pkg/adc_ctl_pkg.sv]
// Types shared by the converter control block
package adc_ctl_pkg;
   // Conversion clock codes
   typedef enum logic [2:0] {
      CLK_DIV2 = 3'h0,
      CLK_DIV8 = 3'h1,
      CLK_DIV32 = 3'h2,
      CLK_RC_A = 3'h3,
      CLK_DIV4 = 3'h4,
      CLK_DIV16 = 3'h5,
      CLK_DIV64 = 3'h6,
      CLK_RC_B = 3'h7
   } conv_clk_t;
   // Whole state of the block
   typedef struct packed {
      logic justify;
      logic [2:0] clkSel;
      logic negRef;
      logic [1:0] posRef;
      logic [3:0] trigSel;
      logic go;
      logic [1:0] irqStat;
      logic [1:0] irqMask;
      logic [6:0] divCnt;
      logic clkTick;
      logic [12:0] sync1;
      logic [12:0] sync2;
      logic [12:0] sync3;
      logic [7:0] rdata;
      logic [7:0] resHigh;
      logic [7:0] resLow;
   } state_t;
endpackage : adc_ctl_pkg

// [sim/adc_config_trigger_result_format_chk.sv]
// Port checker for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_config_trigger_result_format_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register port
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdata,
   // Conversion and selects
   input wire logic convGo,
   input wire logic convDone,
   input wire logic trigPulse,
   input wire logic negRefPin,
   input wire logic posRefSupply,
   input wire logic convClkIsRc
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic goWr;
   logic fmtWr;
   // Software writes to the start bit may override hardware, so they are excluded
   assign goWr = regWrite && regAddr == 3'h6;
   assign fmtWr = regWrite && regAddr == 3'h0;
   a_trig_sets_go: assert property (trigPulse && !goWr |=> convGo)
      else $error("trigger pulse did not start a conversion");
   a_trig_one_cycle: assert property (trigPulse |=> !trigPulse)
      else $error("trigger pulse longer than one cycle");
   a_done_ends_go: assert property (convGo && convDone && !trigPulse && !goWr |=> !convGo)
      else $error("completion left conversion running");
   a_fmt_bit3_zero: assert property (regRead && regAddr == 3'h0 |=> regRdata[3] == 1'b0)
      else $error("format register bit 3 not zero");
   a_trig_low_zero: assert property (regRead && regAddr == 3'h1 |=> regRdata[3:0] == 4'h0)
      else $error("trigger register low bits not zero");
   a_negref_sel: assert property (fmtWr |=> negRefPin == $past(regWdata[2]))
      else $error("negative reference select wrong");
   a_supply_sel: assert property (fmtWr |=> posRefSupply == ($past(regWdata[1:0]) == 2'b00))
      else $error("supply reference select wrong");
   a_rc_clock_sel: assert property (fmtWr |=> convClkIsRc == ($past(regWdata[5:4]) == 2'b11))
      else $error("rc clock select wrong");
endmodule : adc_config_trigger_result_format_chk
bind adc_config_trigger_result_format adc_config_trigger_result_format_chk i_chk (
   .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
   .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .convGo(convGo),
   .convDone(convDone), .trigPulse(trigPulse), .negRefPin(negRefPin),
   .posRefSupply(posRefSupply), .convClkIsRc(convClkIsRc)
);
`default_nettype wire

// [sim/adc_config_trigger_result_format_tb_top.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_config_trigger_result_format_tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic rcOscTick = 1'b0;
   logic [12:0] trig = 13'h0000;
   logic [9:0] sample = 10'h000;
   logic [9:0] convData;
   logic [7:0] regRdata;
   logic [7:0] rdv;
   logic irq, convGo, convClkTick, convClkIsRc, convDone, trigPulse;
   logic negRefPin, posRefSupply, posRefPin, posRefFvr;
   int nErrors = 0;
   int comparisons = 0;

   adc_config_trigger_result_format i_adc_config_trigger_result_format (
      .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq),
      .rcOscTick(rcOscTick), .convDone(convDone), .convData(convData), .convGo(convGo),
      .convClkTick(convClkTick), .convClkIsRc(convClkIsRc), .negRefPin(negRefPin),
      .posRefSupply(posRefSupply), .posRefPin(posRefPin), .posRefFvr(posRefFvr),
      .capture_unit_1(trig[0]), .capture_unit_2(trig[1]), .timer0_wrap_pulse(trig[2]),
      .timer1_wrap_pulse(trig[3]), .timer2_match_pulse(trig[4]),
      .comparator1_synced_out(trig[5]), .comparator2_synced_out(trig[6]),
      .logic_cell1_out(trig[7]), .logic_cell2_out(trig[8]), .logic_cell3_out(trig[9]),
      .logic_cell4_out(trig[10]), .timer4_match_pulse(trig[11]),
      .timer6_match_pulse(trig[12]), .trigPulse(trigPulse)
   );
   conv_core_model i_conv_core_model (
      .ref_clk(ref_clk), .rst(rst), .convGo(convGo), .sample(sample),
      .convDone(convDone), .convData(convData)
   );

   // Free-running system clock
   always #5 ref_clk = ~ref_clk;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         nErrors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Bus cycles; each leaves an idle edge so strobes never toggle twice in a step
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      @(posedge ref_clk);
   endtask : wr

   task automatic rd(input logic [2:0] a);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
      @(negedge ref_clk);
      rdv = regRdata;
      @(posedge ref_clk);
   endtask : rd

   task automatic wait_go(input logic lvl);
      int i;
      for (i = 0; i < 60 && convGo !== lvl; i++) @(negedge ref_clk);
      chk(convGo, lvl);
      if (convGo !== lvl) begin
         stop_test();
      end else begin
         @(posedge ref_clk);
      end
   endtask : wait_go

   task automatic t_regs();
      int p;
      logic [2:0] hot [4] = '{3'b001, 3'b000, 3'b010, 3'b100};
      chk(posRefSupply, 1'b1);
      rd(3'h0);
      chk(rdv, 8'h00);
      rd(3'h1);
      chk(rdv, 8'h00);
      wr(3'h0, 8'hff);
      rd(3'h0);
      chk(rdv, 8'hf7);
      wr(3'h1, 8'hff);
      rd(3'h1);
      chk(rdv, 8'hf0);
      rd(3'h7);
      chk(rdv, 8'h00);
      for (p = 0; p < 4; p++) begin
         wr(3'h0, {5'h00, p[0], p[1:0]});
         chk({posRefFvr, posRefPin, posRefSupply}, hot[p]);
         chk(negRefPin, p[0]);
      end
      $display("register test done");
   endtask : t_regs

   task automatic t_clock();
      int c, n;
      int div [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
      for (c = 0; c < 8; c++) begin
         wr(3'h0, {1'b0, c[2:0], 4'h0});
         if (div[c] == 0) begin
            chk(convClkIsRc, 1'b1);
            rcOscTick <= 1'b1;
            @(posedge ref_clk);
            rcOscTick <= 1'b0;
            for (n = 0; n < 4 && convClkTick !== 1'b1; n++) @(negedge ref_clk);
            chk(convClkTick, 1'b1);
         end else begin
            for (n = 0; n < 70 && convClkTick !== 1'b1; n++) @(negedge ref_clk);
            @(negedge ref_clk);
            for (n = 1; n < 70 && convClkTick !== 1'b1; n++) @(negedge ref_clk);
            chk(n, div[c]);
         end
         @(posedge ref_clk);
      end
      $display("clock test done");
   endtask : t_clock

   task automatic t_trig();
      int k;
      logic [12:0] sel;
      wr(3'h5, 8'h02);
      for (k = 0; k < 16; k++) begin
         sel = (k >= 1 && k <= 13) ? 13'h0001 << (k - 1) : 13'h0000;
         wr(3'h1, {k[3:0], 4'h0});
         // Every other source rises first and must be ignored
         trig <= ~sel;
         repeat (8) @(posedge ref_clk);
         chk(convGo, 1'b0);
         if (sel != 13'h0000) begin
            trig <= 13'h1fff;
            wait_go(1'b1);
            chk(irq, 1'b1);
            wait_go(1'b0);
            repeat (8) @(posedge ref_clk);
            chk(convGo, 1'b0);
         end
         trig <= 13'h0000;
         wr(3'h4, 8'h03);
      end
      $display("trigger test done");
   endtask : t_trig

   task automatic t_result();
      int j;
      logic [9:0] d;
      d = 10'h2b5;
      sample <= d;
      wr(3'h5, 8'h01);
      for (j = 0; j < 2; j++) begin
         wr(3'h0, {j[0], 7'h00});
         wr(3'h6, 8'h01);
         wait_go(1'b0);
         chk(irq, 1'b1);
         rd(3'h2);
         chk(rdv, j ? {6'h00, d[9:8]} : d[9:2]);
         rd(3'h3);
         chk(rdv, j ? d[7:0] : {d[1:0], 6'h00});
         wr(3'h5, 8'h00);
         chk(irq, 1'b0);
         wr(3'h5, 8'h01);
         wr(3'h4, 8'h01);
         chk(irq, 1'b0);
      end
      // Results must survive a reset while control fields clear
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(3'h3);
      chk(rdv, d[7:0]);
      rd(3'h0);
      chk(rdv, 8'h00);
      $display("result test done");
   endtask : t_result

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, nErrors);
      if (nErrors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   // Main sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_regs();
      t_clock();
      t_trig();
      t_result();
      stop_test();
   end
endmodule : adc_config_trigger_result_format_tb_top
`default_nettype wire

// [sim/conv_core_model.sv]
// Behavioural conversion core answering the start level
`timescale 1ns/1ns
`default_nettype none
module conv_core_model #(
   parameter int LAT = 5
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic convGo,
   input wire logic [9:0] sample,
   output logic convDone,
   output logic [9:0] convData
);
   int cnt;
   // Fixed conversion time; data flips outside the done cycle so stale values never match
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         convDone <= 1'b0;
         convData <= 10'h000;
      end else begin
         convDone <= convGo && !convDone && cnt == LAT;
         cnt <= (convGo && !convDone && cnt < LAT) ? cnt + 1 : 0;
         convData <= (convGo && cnt == LAT) ? sample : ~convData;
      end
   end
endmodule : conv_core_model
`default_nettype wire
